/* File: logic/host_port_consts.vh */
// constants for the host port front end
`ifndef HOST_PORT_CONSTS_VH
`define HOST_PORT_CONSTS_VH
`define HP_DATA_W 16
`define HP_ADDR_W 20
`define HP_LO_MSB 7
`define HP_HI_LSB 8
`define HP_HI_MSB 15
`define HP_SEL_ADDR 2'h0
`define HP_SEL_CTRL 2'h1
`define HP_SEL_DATA 2'h2
`define HP_RST_BIT 0
`define HP_CTRL_RESET 16'h0001
`define HP_ZERO16 16'h0000
`define HP_ONES16 16'hFFFF
`define HP_SYNC_PINS 5
`define HP_ZERO20 20'h00000
`endif

/* File: logic/pin_sync.v */
// three-stage synchroniser with agreement filter for one pin
`default_nettype none
module pin_sync (
  input wire ref_clk,
  input wire rst_n,
  input wire init,
  input wire pin,
  output reg level
);
  reg s1;
  reg s2;
  reg s3;
  // s1 feeds only s2; a change counts once s2 and s3 agree
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end
  wire unused_init = init;
endmodule
`default_nettype wire

/* File: logic/host_port_front_end.v */
// host port front end: mode, strobes, latching, register select, byte lanes
`include "host_port_consts.vh"
`default_nettype none
module host_port_front_end #(
  parameter [1:0] sel_addr = `HP_SEL_ADDR,
  parameter [1:0] sel_ctrl = `HP_SEL_CTRL,
  parameter [1:0] sel_data = `HP_SEL_DATA,
  parameter reuse_pins = 1'b0
) (
  input wire ref_clk,
  input wire rst_n,
  input wire mux_select_pin,
  input wire port_select_n,
  input wire data_strobe_a,
  input wire data_strobe_b,
  input wire addr_strobe_n,
  input wire read_not_write,
  input wire [1:0] reg_select,
  input wire [1:0] byte_lane_enable_n,
  input wire [19:0] direct_addr_in,
  input wire [15:0] host_data_in,
  input wire reset_gate_pin,
  input wire [15:0] mem_read_data,
  output reg [15:0] host_data_out,
  output reg [15:0] host_data_oe,
  output reg [19:0] mem_addr,
  output reg [15:0] mem_write_data,
  output reg [1:0] mem_write_lanes,
  output reg mem_write,
  output reg mem_read,
  output reg [15:0] host_addr_reg,
  output reg [15:0] host_ctrl_reg,
  output reg dsp_reset_hold
);
  // only the strobe, select, mode and gate pins pass the three-flop filter; bus and control values are sampled only
  // once the strobe has settled, so the wide buses need no filtering
  // address strobe enters inverted so its idle level matches the flop reset:
  // no false fall right after reset
  wire [4:0] raw_pins = {reset_gate_pin, mux_select_pin, port_select_n ^ 1'b1,
                         data_strobe_a ~^ data_strobe_b, ~addr_strobe_n};
  wire [4:0] sync_pins;
  genvar g;
  generate
    for (g = 0; g < `HP_SYNC_PINS; g = g + 1) begin : sync
      pin_sync u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .init(1'b0),
        .pin(raw_pins[g]),
        .level(sync_pins[g])
      );
    end
  endgenerate
  wire gate_level = sync_pins[4];
  wire mode_direct = sync_pins[3];
  wire selected = sync_pins[2];
  wire strobe_xnor = sync_pins[1];
  wire as_level = sync_pins[0];
  // active high internal strobe, only while the port is selected
  wire access = selected & ~strobe_xnor;
  reg access_d;
  reg as_d;
  wire access_fall = access & ~access_d;
  wire access_rise = ~access & access_d;
  wire as_fall = as_level & ~as_d;
  // latched control
  reg [1:0] lat_sel;
  reg [1:0] lat_be_n;
  reg lat_rnw;
  reg as_seen;
  wire [1:0] eff_sel = mode_direct ? {1'b1, reg_select[0]} : reg_select;
  function [1:0] decode;
    input [1:0] sel;
    input direct;
    begin
      if (direct) begin
        decode = sel[0] ? sel_data : sel_ctrl;
      end else begin
        decode = sel;
      end
    end
  endfunction
  wire [19:0] direct_word = reuse_pins ?
    {direct_addr_in[19:3], addr_strobe_n, reg_select[1], direct_addr_in[0]} :
    direct_addr_in;
  wire [1:0] cur_kind = decode(lat_sel, mode_direct);
  wire [1:0] fall_kind = decode(eff_sel, mode_direct);
  wire [15:0] lane_mask = {{8{~lat_be_n[1]}}, {8{~lat_be_n[0]}}};
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      access_d <= 1'b0;
      as_d <= 1'b0;
      lat_sel <= 2'h0;
      lat_be_n <= 2'h0;
      lat_rnw <= 1'b1;
      as_seen <= 1'b0;
      host_data_out <= `HP_ZERO16;
      host_data_oe <= `HP_ZERO16;
      mem_addr <= `HP_ZERO20;
      mem_write_data <= `HP_ZERO16;
      mem_write_lanes <= 2'h0;
      mem_write <= 1'b0;
      mem_read <= 1'b0;
      host_addr_reg <= `HP_ZERO16;
      host_ctrl_reg <= `HP_CTRL_RESET;
      dsp_reset_hold <= 1'b0;
    end else begin
      access_d <= access;
      as_d <= as_level;
      mem_write <= 1'b0;
      mem_read <= 1'b0;
      // multiplexed with address strobe: control latched on its fall
      if (!mode_direct && as_fall) begin
        lat_sel <= reg_select;
        lat_be_n <= byte_lane_enable_n;
        lat_rnw <= read_not_write;
        as_seen <= 1'b1;
      end
      if (access_fall) begin
        // address strobe held high by the host means latch here instead
        if (mode_direct || !as_seen) begin
          lat_sel <= eff_sel;
          lat_be_n <= byte_lane_enable_n;
          lat_rnw <= read_not_write;
        end
        if (mode_direct) begin
          mem_addr <= direct_word;
        end else begin
          mem_addr <= {4'h0, host_addr_reg};
        end
        if ((mode_direct || !as_seen) ? read_not_write : lat_rnw) begin
          mem_read <= ((mode_direct || !as_seen) ? fall_kind : cur_kind) == sel_data;
        end
      end
      // read data drive: full word except data reads, byte lanes there
      // the latch edge itself still holds the previous direction: wait one cycle
      if (access && !access_fall && lat_rnw) begin
        case (cur_kind)
          sel_addr: host_data_out <= host_addr_reg;
          sel_ctrl: host_data_out <= host_ctrl_reg;
          default: host_data_out <= mem_read_data;
        endcase
        host_data_oe <= (cur_kind == sel_data) ? lane_mask : `HP_ONES16;
      end else begin
        host_data_oe <= `HP_ZERO16;
      end
      if (access_rise) begin
        as_seen <= 1'b0;
        if (!lat_rnw) begin
          case (cur_kind)
            sel_addr: begin
              if (!mode_direct) begin
                host_addr_reg <= host_data_in;
              end
            end
            sel_ctrl: host_ctrl_reg <= host_data_in;
            default: begin
              // 10 writes the low byte, 01 the high byte
              mem_write_data <= host_data_in;
              mem_write_lanes <= ~lat_be_n;
              mem_write <= 1'b1;
            end
          endcase
        end
      end
      // gating pin low masks the reset bit so an unreachable register can't lock
      dsp_reset_hold <= gate_level & host_ctrl_reg[`HP_RST_BIT];
    end
  end
endmodule
`default_nettype wire

/* File: verification/host_model.sv */
// host model: drives one strobe-framed access
`default_nettype none
module host_model (
  input wire ref_clk,
  input wire [15:0] host_data_out,
  input wire [15:0] host_data_oe,
  output var logic port_select_n = 1'b1,
  output var logic data_strobe_a = 1'b1,
  output var logic data_strobe_b = 1'b1,
  output var logic addr_strobe_n = 1'b1,
  output var logic read_not_write = 1'b1,
  output var logic [1:0] reg_select = 2'h0,
  output var logic [1:0] byte_lane_enable_n = 2'h3,
  output var logic [19:0] direct_addr_in = 20'h00000,
  output var logic [15:0] host_data_in = 16'h0000
);
  // long phases: the strobe, select, mode and gate pins are synchronised inside
  task automatic cyc(input logic [1:0] s, input logic r, input logic [1:0] be,
    input logic [19:0] a, input logic [15:0] d, input logic as, input logic b,
    output logic [15:0] q, output logic [15:0] e);
    @(posedge ref_clk);
    port_select_n <= 1'b0;
    read_not_write <= r;
    reg_select <= s;
    byte_lane_enable_n <= be;
    direct_addr_in <= a;
    host_data_in <= d;
    repeat (6) @(posedge ref_clk);
    addr_strobe_n <= !as;
    repeat (6) @(posedge ref_clk);
    if (b) data_strobe_b <= 1'b0;
    else data_strobe_a <= 1'b0;
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
    q = host_data_out;
    e = host_data_oe;
    @(posedge ref_clk);
    data_strobe_a <= 1'b1;
    data_strobe_b <= 1'b1;
    repeat (8) @(posedge ref_clk);
    addr_strobe_n <= 1'b1;
    port_select_n <= 1'b1;
    host_data_in <= ~d; // released lines never keep the old value
    repeat (6) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

/* File: verification/host_port_checker.sv */
// assertions on the host port ports
`default_nettype none
module host_port_checker (
  input wire ref_clk,
  input wire rst_n,
  input wire mux_select_pin,
  input wire port_select_n,
  input wire data_strobe_a,
  input wire data_strobe_b,
  input wire read_not_write,
  input wire reset_gate_pin,
  input wire [15:0] host_data_oe,
  input wire [15:0] host_addr_reg,
  input wire [15:0] host_ctrl_reg,
  input wire dsp_reset_hold,
  input wire mem_read
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  desel_float_a: assert property (port_select_n [*6] |-> !host_data_oe)
    else $error("driven unselected");
  gate_low_a: assert property (!reset_gate_pin [*6] |-> !dsp_reset_hold)
    else $error("reset with gate low");
  ctrl_bit_a: assert property (!host_ctrl_reg[0] |=> !dsp_reset_hold)
    else $error("reset with bit clear");
  lane_oe_a: assert property (host_data_oe inside {16'h0000, 16'h00FF, 16'hFF00, 16'hFFFF})
    else $error("partial lane");
  direct_addr_a: assert property (mux_select_pin [*8] |=> $stable(host_addr_reg))
    else $error("address moved");
  idle_strobe_a: assert property ((data_strobe_a == data_strobe_b) [*8] |->
    !mem_read && !host_data_oe) else $error("access without strobe");
  write_quiet_a: assert property (!read_not_write [*8] |-> !host_data_oe)
    else $error("driven on write");
  read_pulse_a: assert property (mem_read |=> !mem_read)
    else $error("long read");
  cover property (mem_read);
  cover property (host_data_oe == 16'h00FF);
  cover property (mux_select_pin && !dsp_reset_hold);
endmodule
bind host_port_front_end host_port_checker chk (.*);
`default_nettype wire

/* File: verification/host_port_front_end_tb.sv */
// testbench for the host port front end
`default_nettype none
module host_port_front_end_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, rst_n = 0, mux_select_pin = 0, reset_gate_pin = 1, pv = 0;
  logic port_select_n, data_strobe_a, data_strobe_b, addr_strobe_n, read_not_write;
  logic mem_write, mem_read, dsp_reset_hold;
  logic [1:0] reg_select, byte_lane_enable_n, mem_write_lanes, cl;
  logic [19:0] direct_addr_in, mem_addr, ca;
  logic [15:0] host_data_in, host_data_out, host_data_oe, mem_write_data, host_addr_reg;
  logic [15:0] host_ctrl_reg, q, e, cd;
  logic [15:0] mem_read_data = 16'hC35A;
  int errors = 0, cmp_count = 0;
  always #50 ref_clk = ~ref_clk;
  host_port_front_end dut (.*);
  host_model h (.*);
  // outputs are held after the pulse, so take them one edge late
  always @(posedge ref_clk) begin
    pv <= mem_read | mem_write;
    if (pv === 1'b1) begin
      ca <= mem_addr;
      cd <= mem_write_data;
      cl <= mem_write_lanes;
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic end_of_test;
    $display("errors=%0d cmp_count=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1;
    repeat (8) @(posedge ref_clk);
    chk(host_ctrl_reg, 16'h0001);
    chk(dsp_reset_hold, 1);
    h.cyc(0, 0, 3, 0, 16'h1234, 1, 0, q, e);
    chk(host_addr_reg, 16'h1234);
    h.cyc(1, 0, 3, 0, 16'hF0F0, 1, 0, q, e);
    chk(host_ctrl_reg, 16'hF0F0);
    chk(dsp_reset_hold, 0);
    h.cyc(2, 1, 0, 0, 0, 1, 1, q, e);
    chk(ca, 20'h01234);
    chk(q, 16'hC35A);
    h.cyc(0, 0, 0, 0, 16'h00C3, 0, 0, q, e);
    chk(host_addr_reg, 16'h00C3);
    mux_select_pin <= 1;
    h.cyc(1, 0, 2, 20'h08000, 16'h1010, 0, 0, q, e);
    chk({ca, cl}, 22'h020001);
    chk(cd[7:0], 8'h10);
    h.cyc(1, 0, 1, 20'h08000, 16'h3232, 0, 0, q, e);
    chk(cl, 2'h2);
    chk(cd[15:8], 8'h32);
    h.cyc(0, 0, 3, 0, 16'h5555, 0, 0, q, e);
    chk(host_ctrl_reg, 16'h5555);
    chk(host_addr_reg, 16'h00C3);
    chk(dsp_reset_hold, 1);
    h.cyc(1, 1, 2, 20'hABCDE, 0, 0, 0, q, e);
    chk(e, 16'h00FF);
    chk(ca, 20'hABCDE);
    h.cyc(2, 1, 1, 0, 0, 0, 0, q, e);
    chk({q, e}, 32'h5555FFFF);
    reset_gate_pin <= 0;
    repeat (8) @(posedge ref_clk);
    chk(dsp_reset_hold, 0);
    chk(host_data_oe, 16'h0000);
    end_of_test();
  end
endmodule
`default_nettype wire
